// ### rtl/fec_flash_cmd.sv
// serial flash command handling: array erase, sleep entry and wake, id reads
// assumes pins arrive asynchronously and the link clock is much slower than core_clk_i
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// RQ1: host sets write enable before erase
// RQ2: erase is one byte, else dropped
// RQ3: erase sets write_in_progress until done
// RQ4: erase clears write enable latch midway
// RQ5: erase only when fully unprotected
// RQ6: sleep only via sleep command
// RQ7: in sleep only wake and reset accepted
// RQ8: sleep one byte, takes effect after delay
// RQ9: sleep command rejected while busy
// RQ10: power up always in standby
// RQ11: wake waits recovery before new commands
// RQ12: wake command returns repeating device code
// RQ13: wake with code waits longer recovery (the code uses 8000 ns for both WAKE_RECOVERY_NS and WAKE_CODE_RECOV_NS)
// RQ14: wake command ignored while busy
// RQ15: maker/device read, address picks order
// RQ16: dual-line maker/device read
// RQ17: quad-line maker/device read
// RQ18: ident read returns three bytes
// RQ19: ident read ignored while busy
// RQ20: host avoids ident read in sleep
// RQ21: deselect ends output, back to standby
// RQ22: rising edge sampling, falling edge output
module fec_flash_cmd
	import fec_pkg::*;
#(
	parameter int unsigned ERASE_CYC  = ERASE_CYC_DEF,
	parameter logic [7:0]  MAKER_CODE = 8'h5a, // arbitrary value
	parameter logic [7:0]  DEV_CODE   = 8'h3c, // arbitrary value
	parameter logic [7:0]  TYPE_CODE  = 8'h61, // arbitrary value
	parameter logic [7:0]  CAP_CODE   = 8'h19  // arbitrary value
) (
	// clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        reset_n_i,
	// register port
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic [31:0] reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic      [31:0] reg_rdata_o,
	// serial link pins
	input  wire logic        cs_n_i,
	input  wire logic        sclk_i,
	input  wire logic [3:0]  io_i,
	output logic      [3:0]  io_o,
	output logic      [3:0]  io_oe_o
);

	// id byte for the current read, by opcode and byte position
	function automatic logic [7:0] ident_byte(input logic [7:0] op, input logic [1:0] idx);
		logic [7:0] b;
		b = DEV_CODE;
		if (op == OP_IDENT)
			b = (idx == 2'h0) ? MAKER_CODE : (idx == 2'h1) ? TYPE_CODE : CAP_CODE;
		else if (op != OP_WAKE)
			b = (idx == 2'h0) ? MAKER_CODE : DEV_CODE;
		return b;
	endfunction

	// number of id bytes before the sequence repeats
	function automatic logic [1:0] ident_len(input logic [7:0] op);
		return (op == OP_IDENT) ? 2'h3 : (op == OP_WAKE) ? 2'h1 : 2'h2;
	endfunction

	// whether an opcode may start in the present device state
	function automatic logic cmd_allowed(input logic [7:0] op, input logic slp,
			input logic blocked);
		logic ok;
		ok = !blocked;
		if (slp)
			ok = ok && (op == OP_WAKE || op == OP_RST_EN || op == OP_RST);
		return ok;
	endfunction

	logic [5:0]  sync1_reg;
	logic [5:0]  sync2_reg;
	logic [5:0]  sync3_reg;
	fec_pins_t   pin_reg;
	logic        sclk_prev_reg;
	logic        cs_prev_reg;
	fec_frame_t  frame_reg;
	logic [7:0]  opc_reg;
	logic [4:0]  bit_cnt_reg;
	logic [2:0]  lane_w_reg;
	logic [1:0]  out_idx_reg;
	logic [3:0]  out_pos_reg;
	logic [7:0]  out_byte_reg;
	logic        wip_reg;
	logic        wel_reg;
	logic [31:0] erase_cnt_reg;
	logic        sleep_reg;
	logic [31:0] sleep_cnt_reg;
	logic [31:0] wake_cnt_reg;
	logic        rst_arm_reg;
	logic [3:0]  protect_reg;
	logic        first_cyc_reg;
	logic        sclk_rise;
	logic        sclk_fall;
	logic        cs_rise;
	logic        cs_fall;
	logic [7:0]  opc_full;
	logic        opc_done;
	logic        waking;
	logic        protect_ok;
	logic        exec_valid;
	logic        start_erase;
	logic        wake_exec;
	logic [7:0]  cur_byte;

	// three-stage pin capture; a bit moves on only once stages two and three agree
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sync1_reg <= 6'h3f;
			sync2_reg <= 6'h3f;
			sync3_reg <= 6'h3f;
			pin_reg   <= fec_pins_t'(6'h3f);
		end else begin
			sync1_reg <= {cs_n_i, sclk_i, io_i};
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			pin_reg   <= fec_pins_t'((sync2_reg & sync3_reg)
				| (6'(pin_reg) & (sync2_reg ^ sync3_reg)));
		end
	end

	// edge history of the filtered select and clock
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sclk_prev_reg <= 1'b1;
			cs_prev_reg   <= 1'b1;
		end else begin
			sclk_prev_reg <= pin_reg.sclk;
			cs_prev_reg   <= pin_reg.cs_n;
		end
	end

	// link events and command qualifiers
	assign sclk_rise   = pin_reg.sclk & ~sclk_prev_reg & ~pin_reg.cs_n;
	assign sclk_fall   = ~pin_reg.sclk & sclk_prev_reg & ~pin_reg.cs_n;
	assign cs_rise     = pin_reg.cs_n & ~cs_prev_reg;
	assign cs_fall     = ~pin_reg.cs_n & cs_prev_reg;
	assign opc_full    = {opc_reg[6:0], pin_reg.io[0]};
	assign opc_done    = (frame_reg == S_OPC) && sclk_rise && (bit_cnt_reg == 5'h07);
	assign waking      = (sleep_cnt_reg != 32'h0) || (wake_cnt_reg != 32'h0);
	assign protect_ok  = (protect_reg[PR_BP_LSB +: 3] == 3'h0 && !protect_reg[PR_CMP_BIT])
		|| (protect_reg[PR_BP_LSB +: 3] == 3'h7 && protect_reg[PR_CMP_BIT]); // RQ5
	assign exec_valid  = cs_rise && (frame_reg == S_TAIL); // RQ2
	assign start_erase = exec_valid && (opc_reg == OP_ERASE_A || opc_reg == OP_ERASE_B)
		&& wel_reg && protect_ok; // RQ1
	assign wake_exec   = cs_rise && sleep_reg && (opc_reg == OP_WAKE)
		&& (frame_reg == S_ARG || frame_reg == S_OUT);
	assign cur_byte    = (out_pos_reg == 4'h0) ? ident_byte(opc_reg, out_idx_reg) : out_byte_reg;

	// frame sequencer: opcode, argument, output, or wait for deselect
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			frame_reg   <= S_IDLE;
			opc_reg     <= 8'h00;
			bit_cnt_reg <= 5'h00;
			lane_w_reg  <= 3'h1;
			out_idx_reg <= 2'h0;
		end else if (pin_reg.cs_n) begin
			frame_reg <= S_IDLE; // RQ21
		end else if (cs_fall) begin
			frame_reg   <= S_OPC;
			bit_cnt_reg <= 5'h00;
			lane_w_reg  <= 3'h1;
			out_idx_reg <= 2'h0;
		end else begin
			unique case (frame_reg)
				S_IDLE: begin
					frame_reg <= S_DROP; // selected mid-frame: wait for next select
				end
				S_OPC: if (sclk_rise) begin
					opc_reg     <= opc_full; // RQ22
					bit_cnt_reg <= 5'(bit_cnt_reg + 5'h01);
					if (bit_cnt_reg == 5'h07) begin
						bit_cnt_reg <= 5'h00;
						if (!cmd_allowed(opc_full, sleep_reg, wip_reg || waking))
							frame_reg <= S_DROP; // RQ7 RQ9 RQ11 RQ14 RQ19
						else if (opc_full == OP_WAKE)
							frame_reg <= S_ARG;
						else if (opc_full == OP_ID_X1 || opc_full == OP_ID_X2
								|| opc_full == OP_ID_X4) begin
							frame_reg  <= S_ARG;
							lane_w_reg <= (opc_full == OP_ID_X4) ? 3'h4
								: (opc_full == OP_ID_X2) ? 3'h2 : 3'h1; // RQ16 RQ17
						end else if (opc_full == OP_IDENT)
							frame_reg <= S_OUT; // RQ18
						else if (opc_full == OP_WRITE_ENABLE || opc_full == OP_ERASE_A
								|| opc_full == OP_ERASE_B || opc_full == OP_SLEEP
								|| opc_full == OP_RST_EN || opc_full == OP_RST)
							frame_reg <= S_TAIL;
						else
							frame_reg <= S_DROP;
					end
				end
				S_ARG: if (sclk_rise) begin
					bit_cnt_reg <= 5'(bit_cnt_reg + 5'(lane_w_reg));
					if (5'(bit_cnt_reg + 5'(lane_w_reg)) == ARG_BITS) begin
						frame_reg <= S_OUT; // RQ12
						// last address bit picks which code comes first
						if (opc_reg != OP_WAKE)
							out_idx_reg <= {1'b0, pin_reg.io[0]}; // RQ15
					end
				end
				S_OUT: if (sclk_fall && (4'(out_pos_reg + 4'(lane_w_reg)) == 4'h8)) begin
					out_idx_reg <= (2'(out_idx_reg + 2'h1) == ident_len(opc_reg))
						? 2'h0 : 2'(out_idx_reg + 2'h1); // RQ12
				end
				S_TAIL: if (sclk_rise) begin
					frame_reg <= S_DROP; // RQ2 RQ8
				end
				S_DROP: begin
					frame_reg <= S_DROP;
				end
				default: begin
					frame_reg <= S_DROP;
				end
			endcase
		end
	end

	// output shifter: data changes only on falling edges, msb first
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			out_pos_reg  <= 4'h0;
			out_byte_reg <= 8'h00;
			io_o         <= 4'h0;
			io_oe_o      <= 4'h0;
		end else if (frame_reg != S_OUT) begin
			out_pos_reg <= 4'h0;
			io_oe_o     <= 4'h0; // RQ21
		end else if (sclk_fall) begin
			out_pos_reg <= (4'(out_pos_reg + 4'(lane_w_reg)) == 4'h8)
				? 4'h0 : 4'(out_pos_reg + 4'(lane_w_reg)); // RQ22
			unique case (lane_w_reg)
				3'h4: begin
					io_o         <= cur_byte[7:4]; // RQ17
					io_oe_o      <= 4'hf;
					out_byte_reg <= {cur_byte[3:0], 4'h0};
				end
				3'h2: begin
					io_o         <= {2'h0, cur_byte[7:6]}; // RQ16
					io_oe_o      <= 4'h3;
					out_byte_reg <= {cur_byte[5:0], 2'h0};
				end
				default: begin
					io_o         <= {2'h0, cur_byte[7], 1'b0}; // RQ15 RQ18
					io_oe_o      <= 4'h2;
					out_byte_reg <= {cur_byte[6:0], 1'b0};
				end
			endcase
		end
	end

	// self-timed array erase; the latch is dropped halfway so it is clear before the end
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wip_reg       <= 1'b0;
			erase_cnt_reg <= 32'h0;
		end else if (start_erase) begin
			wip_reg       <= 1'b1; // RQ3
			erase_cnt_reg <= 32'(ERASE_CYC);
		end else if (wip_reg) begin
			erase_cnt_reg <= 32'(erase_cnt_reg - 32'h1);
			if (erase_cnt_reg == 32'h1)
				wip_reg <= 1'b0; // RQ3
		end
	end

	// write enable latch; a set and a midway clear never meet since commands wait out erase
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wel_reg <= 1'b0;
		end else if (exec_valid && opc_reg == OP_WRITE_ENABLE) begin
			wel_reg <= 1'b1;
		end else if (wip_reg && erase_cnt_reg == 32'(ERASE_CYC / 2)) begin
			wel_reg <= 1'b0; // RQ4
		end else if (exec_valid && opc_reg == OP_RST && rst_arm_reg) begin
			wel_reg <= 1'b0;
		end
	end

	// reset arming: the reset opcode counts only right after reset-enable
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			rst_arm_reg <= 1'b0;
		else if (cs_rise)
			rst_arm_reg <= exec_valid && (opc_reg == OP_RST_EN);
	end

	// sleep entry delay, sleep state and wake recovery; reset lands in standby
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sleep_reg     <= 1'b0; // RQ10
			sleep_cnt_reg <= 32'h0;
			wake_cnt_reg  <= 32'h0;
		end else begin
			if (exec_valid && opc_reg == OP_SLEEP)
				sleep_cnt_reg <= 32'(SLEEP_ENTRY_CYC); // RQ6 RQ8
			else if (sleep_cnt_reg != 32'h0)
				sleep_cnt_reg <= 32'(sleep_cnt_reg - 32'h1);
			if (sleep_cnt_reg == 32'h1)
				sleep_reg <= 1'b1; // RQ8
			else if (wake_exec || (exec_valid && opc_reg == OP_RST && rst_arm_reg))
				sleep_reg <= 1'b0; // RQ7
			// a bare wake frame ends after the opcode; any longer wake frame takes the code recovery
			if (wake_exec)
				wake_cnt_reg <= (frame_reg == S_ARG && bit_cnt_reg == 5'h00)
					? 32'(WAKE_RECOVERY_CYC) : 32'(WAKE_CODE_CYC); // RQ11 RQ13
			else if (wake_cnt_reg != 32'h0)
				wake_cnt_reg <= 32'(wake_cnt_reg - 32'h1);
		end
	end

	// marks the first cycle after reset release
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			first_cyc_reg <= 1'b1;
		else
			first_cyc_reg <= 1'b0;
	end

	// software protect register
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			protect_reg <= PROTECT_RST;
		else if (reg_wr_i && reg_addr_i == REG_PROTECT)
			protect_reg <= reg_wdata_i[3:0];
	end

	// read data stand one cycle after the strobe; unmapped reads return zero
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			reg_rdata_o <= 32'h0;
		else if (reg_rd_i && reg_addr_i == REG_STATUS) begin
			reg_rdata_o                <= 32'h0;
			reg_rdata_o[ST_WIP_BIT]    <= wip_reg;
			reg_rdata_o[ST_WEL_BIT]    <= wel_reg;
			reg_rdata_o[ST_SLEEP_BIT]  <= sleep_reg;
			reg_rdata_o[ST_WAKING_BIT] <= waking;
		end else if (reg_rd_i && reg_addr_i == REG_PROTECT)
			reg_rdata_o <= {28'h0, protect_reg};
		else
			reg_rdata_o <= 32'h0;
	end

	property p_one_byte_only;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		(frame_reg == S_TAIL && sclk_rise) |=> (frame_reg == S_DROP || frame_reg == S_IDLE);
	endproperty
	a_one_byte_only: assert property (p_one_byte_only) else $error("extra bit kept command"); // RQ2

	property p_erase_busy;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		$fell(wip_reg) |-> $past(erase_cnt_reg) == 32'h1;
	endproperty
	a_erase_busy: assert property (p_erase_busy) else $error("busy ended early"); // RQ3

	property p_latch_cleared;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		$fell(wip_reg) |-> !wel_reg;
	endproperty
	a_latch_cleared: assert property (p_latch_cleared) else $error("latch set after erase"); // RQ4

	property p_protect_gate;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		$rose(wip_reg) |-> $past(protect_ok && wel_reg);
	endproperty
	a_protect_gate: assert property (p_protect_gate) else $error("erase while protected"); // RQ5

	property p_sleep_by_cmd;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		$rose(sleep_reg) |-> $past(sleep_cnt_reg) == 32'h1;
	endproperty
	a_sleep_by_cmd: assert property (p_sleep_by_cmd) else $error("sleep without command"); // RQ6

	property p_sleep_filter;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		(sleep_reg && opc_done && opc_full != OP_WAKE && opc_full != OP_RST_EN
			&& opc_full != OP_RST) |=> frame_reg == S_DROP;
	endproperty
	a_sleep_filter: assert property (p_sleep_filter) else $error("command taken in sleep"); // RQ7

	property p_sleep_delay;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		(exec_valid && opc_reg == OP_SLEEP) |=> !sleep_reg ##1 !sleep_reg;
	endproperty
	a_sleep_delay: assert property (p_sleep_delay) else $error("sleep too soon"); // RQ8

	property p_sleep_busy;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		(wip_reg && opc_done && opc_full == OP_SLEEP) |=> frame_reg == S_DROP;
	endproperty
	a_sleep_busy: assert property (p_sleep_busy) else $error("sleep taken while busy"); // RQ9

	property p_powerup;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		first_cyc_reg |-> (!sleep_reg && !waking && !wip_reg);
	endproperty
	a_powerup: assert property (p_powerup) else $error("not standby after reset"); // RQ10

	property p_recovery_block;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		(wake_cnt_reg != 32'h0 && opc_done) |=> frame_reg == S_DROP;
	endproperty
	a_recovery_block: assert property (p_recovery_block) else $error("command in recovery"); // RQ11

	property p_wake_code;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		(frame_reg == S_OUT && opc_reg == OP_WAKE && sclk_fall && out_pos_reg == 4'h0)
			|=> io_o[1] == DEV_CODE[7];
	endproperty
	a_wake_code: assert property (p_wake_code) else $error("wrong device code"); // RQ12

	property p_code_recovery;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		(wake_exec && frame_reg == S_OUT) |=> (!sleep_reg && wake_cnt_reg == 32'(WAKE_CODE_CYC));
	endproperty
	a_code_recovery: assert property (p_code_recovery) else $error("wrong recovery"); // RQ13

	property p_wake_busy;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		(wip_reg && opc_done && opc_full == OP_WAKE) |=> frame_reg == S_DROP;
	endproperty
	a_wake_busy: assert property (p_wake_busy) else $error("wake taken while busy"); // RQ14

	property p_id_order;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		(frame_reg == S_OUT && opc_reg == OP_ID_X1 && sclk_fall && out_pos_reg == 4'h0)
			|=> io_o[1] == (($past(out_idx_reg) == 2'h0) ? MAKER_CODE[7] : DEV_CODE[7]);
	endproperty
	a_id_order: assert property (p_id_order) else $error("id order wrong"); // RQ15

	property p_id_dual;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		(frame_reg == S_OUT && opc_reg == OP_ID_X2 && sclk_fall) |=> io_oe_o == 4'h3;
	endproperty
	a_id_dual: assert property (p_id_dual) else $error("dual lanes wrong"); // RQ16

	property p_id_quad;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		(frame_reg == S_OUT && opc_reg == OP_ID_X4 && sclk_fall && out_pos_reg == 4'h0)
			|=> (io_oe_o == 4'hf && io_o == (($past(out_idx_reg) == 2'h0)
				? MAKER_CODE[7:4] : DEV_CODE[7:4]));
	endproperty
	a_id_quad: assert property (p_id_quad) else $error("quad lanes wrong"); // RQ17

	property p_ident_cap;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		(frame_reg == S_OUT && opc_reg == OP_IDENT && sclk_fall && out_pos_reg == 4'h0
			&& out_idx_reg == 2'h2) |=> io_o[1] == CAP_CODE[7];
	endproperty
	a_ident_cap: assert property (p_ident_cap) else $error("capacity byte wrong"); // RQ18

	property p_ident_busy;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		(wip_reg && opc_done && opc_full == OP_IDENT) |=> frame_reg == S_DROP;
	endproperty
	a_ident_busy: assert property (p_ident_busy) else $error("ident taken while busy"); // RQ19

	property p_deselect;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		cs_rise |=> (frame_reg == S_IDLE ##1 io_oe_o == 4'h0);
	endproperty
	a_deselect: assert property (p_deselect) else $error("output after deselect"); // RQ21

	property p_rise_sample;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		(frame_reg == S_OPC && sclk_rise) |=> opc_reg[0] == $past(pin_reg.io[0]);
	endproperty
	a_rise_sample: assert property (p_rise_sample) else $error("bit not sampled"); // RQ22

endmodule

`default_nettype wire

// ### include/fec_pkg.sv
// constants, field layouts and carrier types for the flash command block
// assumes a 250 MHz core clock; the serial link is sampled, not clocked on
package fec_pkg;

	// core clock period in ns
	localparam int unsigned CLK_PERIOD_NS = 4;

	// a least time in ns rounded up to whole core cycles, never below one
	function automatic int unsigned cyc_ceil(input int unsigned ns);
		int unsigned c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c == 0) ? 1 : c;
	endfunction

	// opcodes seen on the link
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_ERASE_A      = 8'h60;
	localparam logic [7:0] OP_ERASE_B      = 8'hc7;
	localparam logic [7:0] OP_SLEEP        = 8'hb9;
	localparam logic [7:0] OP_WAKE         = 8'hab;
	localparam logic [7:0] OP_RST_EN       = 8'h66;
	localparam logic [7:0] OP_RST          = 8'h99;
	localparam logic [7:0] OP_ID_X1        = 8'h90;
	localparam logic [7:0] OP_ID_X2        = 8'h92;
	localparam logic [7:0] OP_ID_X4        = 8'h94;
	localparam logic [7:0] OP_IDENT        = 8'h9f;

	// argument lengths in bits: three dummy bytes, or a 24-bit address
	localparam logic [4:0] ARG_BITS = 5'h18;

	// timing, in ns as given, then in cycles
	localparam int unsigned SLEEP_ENTRY_NS     = 3000;
	localparam int unsigned WAKE_RECOVERY_NS   = 8000;
	localparam int unsigned WAKE_CODE_RECOV_NS = 8000;
	localparam int unsigned ERASE_DURATION_NS  = 20000000;
	localparam int unsigned SLEEP_ENTRY_CYC    = cyc_ceil(SLEEP_ENTRY_NS);
	localparam int unsigned WAKE_RECOVERY_CYC  = cyc_ceil(WAKE_RECOVERY_NS);
	localparam int unsigned WAKE_CODE_CYC      = cyc_ceil(WAKE_CODE_RECOV_NS);
	localparam int unsigned ERASE_CYC_DEF      = cyc_ceil(ERASE_DURATION_NS);

	// register map, byte addresses
	localparam logic [7:0] REG_STATUS  = 8'h00;
	localparam logic [7:0] REG_PROTECT = 8'h04;

	// status fields
	localparam int unsigned ST_WIP_BIT    = 0;
	localparam int unsigned ST_WEL_BIT    = 1;
	localparam int unsigned ST_SLEEP_BIT  = 2;
	localparam int unsigned ST_WAKING_BIT = 3;

	// protect fields and reset value
	localparam int unsigned PR_BP_LSB   = 0;
	localparam int unsigned PR_CMP_BIT  = 3;
	localparam logic [3:0]  PROTECT_RST = 4'h0;

	// serial frame states
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_OPC  = 3'b001,
		S_ARG  = 3'b010,
		S_OUT  = 3'b011,
		S_TAIL = 3'b100,
		S_DROP = 3'b101
	} fec_frame_t;

	// pin carrier: select, serial clock and the four data lines
	typedef struct packed {
		logic       cs_n;
		logic       sclk;
		logic [3:0] io;
	} fec_pins_t;

endpackage

// ### sim/fec_host_model.sv
// host model of the flash link: select, serial clock, data lines
// assumes a 4 ns core clock; one link bit spans 16 core cycles
`timescale 1ns/1ps
`default_nettype none
module fec_host_model (
	// clock
	input  wire logic       clk_i,
	// link pins
	output logic            cs_n_o,
	output logic            sclk_o,
	output logic      [3:0] io_o,
	output logic      [3:0] io_oe_o,
	input  wire logic [3:0] io_i
);
	// idle: deselected, clock parked low between frames
	initial begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		io_o = 4'h0;
		io_oe_o = 4'h0;
	end
	// half of the 64 ns link period
	task automatic half();
		repeat (8) @(posedge clk_i);
	endtask
	// one bit time; released lines invert so no stale value looks valid
	task automatic pulse(input logic [3:0] v, input logic [3:0] oe, input int ln,
			inout logic [23:0] rd);
		sclk_o <= 1'b0;
		io_oe_o <= oe;
		io_o <= (v & oe) | (~io_o & ~oe);
		half();
		rd = (rd << ln) | 24'((ln == 1) ? {3'h0, io_i[1]} : io_i & 4'((1 << ln) - 1));
		sclk_o <= 1'b1;
		half();
	endtask
	// opcode on io0, argument over ln lanes, then nout bits back
	task automatic frame(input logic [7:0] op, input int ln, input logic [23:0] arg,
			input int nab, input int nout, output logic [23:0] rd);
		logic [23:0] sh;
		sh = arg << (24 - nab);
		rd = 24'h0;
		cs_n_o <= 1'b0;
		half();
		for (int i = 7; i >= 0; i--) begin
			pulse({3'h0, op[i]}, 4'h1, 1, rd);
		end
		for (int i = 0; i < nab / ln; i++) begin
			pulse(sh[23:20] >> (4 - ln), 4'((1 << ln) - 1), ln, rd);
			sh = sh << ln;
		end
		rd = 24'h0;
		for (int i = 0; i < nout / ln; i++) begin
			pulse(4'h0, 4'h0, ln, rd);
		end
		sclk_o <= 1'b0;
		io_oe_o <= 4'h0;
		half();
		cs_n_o <= 1'b1;
		half();
		half();
	endtask
endmodule
`default_nettype wire

// ### sim/fec_flash_cmd_tb.sv
// bench for the flash command block: register port plus host link model
// assumes fec_pkg and the host model compiled first
`timescale 1ns/1ps
`default_nettype none
module fec_flash_cmd_tb
	import fec_pkg::*;
;
	localparam logic [7:0] MK = 8'ha5; // arbitrary value
	localparam logic [7:0] DV = 8'hc3; // arbitrary value
	localparam logic [7:0] TY = 8'h16; // arbitrary value
	localparam logic [7:0] CP = 8'h91; // arbitrary value
	logic clk, rst_n, wr, rd, cs_n, sclk, oe_seen;
	logic [7:0] addr;
	logic [31:0] wdata, rdata;
	logic [3:0] h_io, h_oe, d_io, d_oe, io_w;
	int errors, compares;
	// each line carries the device where it drives, else the host
	assign io_w = (d_oe & d_io) | (~d_oe & h_io);
	fec_flash_cmd #(.ERASE_CYC(4000), .MAKER_CODE(MK), .DEV_CODE(DV), .TYPE_CODE(TY),
		.CAP_CODE(CP)) dut (.core_clk_i(clk), .reset_n_i(rst_n), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
		.cs_n_i(cs_n), .sclk_i(sclk), .io_i(io_w), .io_o(d_io), .io_oe_o(d_oe));
	fec_host_model host (.clk_i(clk), .cs_n_o(cs_n), .sclk_o(sclk), .io_o(h_io),
		.io_oe_o(h_oe), .io_i(io_w));
	// 250 MHz core clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// note any drive by the device, for frames that must stay silent;
	// host and device must never drive one line in the same cycle
	always @(posedge clk) begin
		if (d_oe !== 4'h0) oe_seen = 1'b1;
		if (rst_n) chk("contention", 32'(d_oe & h_oe), 32'h0);
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic st(input logic [31:0] e);
		logic [31:0] v;
		reg_rd(REG_STATUS, v);
		chk("status", v, e);
	endtask
	// bounded wait on the status word; a miss ends the run
	task automatic poll(input logic [31:0] e);
		logic [31:0] v;
		for (int i = 0; i < 2500; i++) begin
			reg_rd(REG_STATUS, v);
			if (v === e) return;
		end
		chk("status_wait", v, e);
		give_verdict();
	endtask
	task automatic cmd(input logic [7:0] op);
		logic [23:0] r;
		host.frame(op, 1, 24'h0, 0, 0, r);
	endtask
	task automatic t_reset();
		logic [31:0] v;
		reg_wr(REG_STATUS, 32'hf);
		st(32'h0);
		reg_wr(8'h08, 32'hf);
		reg_rd(8'h08, v);
		chk("unmapped", v, 32'h0);
		reg_rd(REG_PROTECT, v);
		chk("protect", v, 32'h0);
	endtask
	task automatic t_ids();
		logic [23:0] r;
		logic [7:0] ops [3];
		ops = '{OP_ID_X1, OP_ID_X2, OP_ID_X4};
		host.frame(OP_IDENT, 1, 24'h0, 0, 8, r);
		chk("ident_cut", 32'(r), 32'(MK));
		for (int i = 0; i < 6; i++) begin
			host.frame(ops[i / 2], 1 << (i / 2), 24'(i % 2), 24, 16, r);
			chk("maker_dev", 32'(r), (i % 2) ? {16'h0, DV, MK} : {16'h0, MK, DV});
		end
		host.frame(OP_IDENT, 1, 24'h0, 0, 24, r);
		chk("ident", 32'(r), {8'h0, MK, TY, CP});
		host.frame(OP_WAKE, 1, 24'h0, 24, 16, r);
		chk("dev_code", 32'(r), {16'h0, DV, DV});
		poll(32'h0);
	endtask
	// refused erases first, then one run per allowed protect setting
	task automatic t_erase();
		logic [23:0] r;
		cmd(OP_ERASE_B);
		st(32'h0);
		cmd(OP_WRITE_ENABLE);
		reg_wr(REG_PROTECT, 32'h1);
		cmd(OP_ERASE_A);
		reg_wr(REG_PROTECT, 32'h8);
		cmd(OP_ERASE_B);
		st(32'h2);
		reg_wr(REG_PROTECT, 32'h0);
		host.frame(OP_ERASE_A, 1, 24'h0, 1, 0, r);
		st(32'h2);
		for (int k = 0; k < 2; k++) begin
			reg_wr(REG_PROTECT, 32'(k * 15));
			cmd(OP_WRITE_ENABLE);
			cmd(k ? OP_ERASE_A : OP_ERASE_B);
			st(32'h3);
			oe_seen = 1'b0;
			host.frame(OP_IDENT, 1, 24'h0, 0, 24, r);
			host.frame(OP_WAKE, 1, 24'h0, 24, 8, r);
			cmd(OP_SLEEP);
			chk("busy_drive", 32'(oe_seen), 32'h0);
			poll(32'h1);
			poll(32'h0);
		end
	endtask
	// three ways out of sleep: plain wake, wake with code, reset pair
	task automatic t_sleep();
		logic [23:0] r;
		for (int k = 0; k < 3; k++) begin
			cmd(OP_SLEEP);
			st(32'h8);
			repeat (760) @(posedge clk);
			oe_seen = 1'b0;
			host.frame(OP_ID_X1, 1, 24'h0, 24, 16, r);
			cmd(OP_WRITE_ENABLE);
			st(32'h4);
			chk("sleep_drive", 32'(oe_seen), 32'h0);
			if (k == 2) begin
				cmd(OP_RST_EN);
				st(32'h4);
				cmd(OP_RST);
			end else begin
				host.frame(OP_WAKE, 1, 24'h0, k * 24, k * 8, r);
				chk("wake_code", 32'(r), k ? 32'(DV) : 32'h0);
				st(32'h8);
				cmd(OP_WRITE_ENABLE);
			end
			poll(32'h0);
		end
	endtask
	// reset, then the scenarios in turn
	initial begin
		rst_n = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdata = 32'h0;
		oe_seen = 1'b0;
		errors = 0;
		compares = 0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge clk);
		t_reset();
		t_ids();
		t_erase();
		t_sleep();
		give_verdict();
	end
endmodule
`default_nettype wire
